// ===== rtl/afc_host.sv
// Host controller that drives an asynchronous 9-bit FIFO over its pins.
//
// Overview of operation
// - Wait empty-release delay after write.
// - Strobes held high during rewind recovery.
// - Standalone: chain-in low, first-load high.
// - Width slices share controls; nine-bit steps.
// - Depth ring chosen during master clear.
// - First-load low on first device only.
// - Composite flags OR all device flags.
// - Use empty and full to gate access.
`timescale 1ns/1ps
module afc_host
    import afc_pkg::*;
#(
    parameter int SLICES = 1,
    parameter int DEVS = 1
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic READ_N,
    output logic WRITE_N,
    output logic REWIND_N,
    output logic MASTER_CLEAR_N,
    output logic [SLICES*AFC_DW-1:0] DATA_IN_BUS,
    input wire logic [SLICES*AFC_DW-1:0] DATA_OUT_BUS,
    input wire logic [DEVS-1:0] EMPTY_FLAG_N,
    input wire logic [DEVS-1:0] FULL_FLAG_N,
    input wire logic HALF_LEVEL_FLAG_N,
    output logic CHAIN_IN_N,
    output logic FIRST_LOAD_N
);
    localparam int W = SLICES * AFC_DW;
    // Register map, as software sees it over the memory-mapped port.
    // The control register starts a master clear with bit zero.
    // In the same write, bit two chooses the depth expansion strap.
    // Bit one of the control register starts a rewind pulse.
    // A rewind is dropped quietly while the depth strap is set.
    // A write to the write data register stores one word in the FIFO.
    // The word is kept on the data pins until the next write.
    // A read of the read data register returns the previous word.
    // The same read starts a new fetch if the FIFO holds a word.
    // Software therefore drains n words with n plus one reads.
    // The status register shows busy, empty, full, half, strap.
    // Its top status bit records a read that the empty flag refused.
    // That bit is cleared by a status read, but a new refusal wins.
    //
    // Bus timing, as the master sees it.
    // An access is taken only while the sequencer is idle.
    // Waitrequest then drops for exactly one cycle after it is taken.
    // Read data stands from that same cycle until the next access is taken.
    // After that cycle, waitrequest stays high while a strobe sequence runs.
    // The master may therefore issue accesses back to back safely.
    //
    // Strobe timing toward the FIFO device.
    // Every strobe is held low for the least pulse width, rounded up.
    // After the strobe rises, a recovery count keeps all strobes high.
    // After a write, the recovery count covers the empty release delay.
    // This keeps a read from starting before the empty flag is valid.
    // After a rewind, the recovery count covers the rewind recovery.
    // After a read or a clear, the plain recovery time is used.
    // Only one strobe is ever low at a time, by construction.
    //
    // Data capture.
    // The device drives its outputs only while the read strobe is low.
    // The outputs are sampled at the edge that raises the strobe again.
    // At that edge the word has stood for the whole pulse width.
    // A sample taken later would see a floating bus.
    //
    // Flags.
    // Each flag input is taken as synchronous to the clock.
    // With several devices in depth, the flags are combined here.
    // Any device that shows empty makes the whole system empty.
    // Any device that shows full makes the whole system full.
    // The half flag is shown only outside depth expansion.
    //
    // Straps.
    // The chain input is held low, as a standalone device expects.
    // The first-load pin follows the inverse of the depth strap.
    // In depth expansion the device chain passes its own token.
    // The controller then only watches the combined flags.
    //
    // Limitations a user must know.
    // A master clear must be issued once before the first access.
    // A rewind only replays words written since the last clear.
    // Words beyond the device depth cannot be replayed at all.
    // Writes while full are dropped without any status report.
    // The timing counts assume the slowest device speed grade.
    // A faster clock needs wider counts and a wider counter.
    //
    // Sequencer state and timing counter.
    afc_state_type state_r, state_nxt;
    logic [AFC_CW-1:0] cnt_r, cnt_nxt;
    // Depth expansion strap, captured from the control register.
    logic depth_r;
    // Last word read from the FIFO and the pending write word.
    logic [W-1:0] rdata_r;
    logic [W-1:0] wdata_r;
    // Sticky flag: a read was refused because the FIFO was empty.
    logic rd_refused_r;
    // Pin outputs.
    afc_strobe_type pins_r, pins_nxt;
    logic [31:0] rdout_r;
    logic wait_r;

    // Composite flags: any device low means the system is empty or full.
    wire logic sys_empty = ~(&EMPTY_FLAG_N);
    wire logic sys_full = ~(&FULL_FLAG_N);
    // Register decodes.
    wire logic sel_ctrl = AVS_ADDRESS == AFC_REG_CTRL;
    wire logic sel_wd = AVS_ADDRESS == AFC_REG_WDATA;
    wire logic sel_rd = AVS_ADDRESS == AFC_REG_RDATA;
    wire logic sel_st = AVS_ADDRESS == AFC_REG_STAT;
    wire logic busy = state_r != AFC_IDLE;
    wire logic cnt_done = cnt_r == '0;
    // A bus access is accepted only in the idle state for one cycle.
    wire logic take = ~busy & wait_r & (AVS_READ | AVS_WRITE);
    wire logic go_rd = take & AVS_READ & sel_rd & ~sys_empty;
    wire logic go_wr = take & AVS_WRITE & sel_wd & ~sys_full;
    wire logic go_mr = take & AVS_WRITE & sel_ctrl
        & AVS_WRITEDATA[AFC_CTRL_RESET];
    // Rewind is refused when the strap selects depth expansion.
    wire logic go_rt = take & AVS_WRITE & sel_ctrl & ~go_mr
        & AVS_WRITEDATA[AFC_CTRL_REWIND] & ~depth_r;
    // Half flag is only meaningful outside depth expansion.
    wire logic half_ok = ~depth_r & ~HALF_LEVEL_FLAG_N;
    wire logic [31:0] stat_word = {26'h000_0000, rd_refused_r, depth_r,
        half_ok, sys_full, sys_empty, busy};
    wire logic [31:0] rd_word = sel_st ? stat_word :
        sel_rd ? {{(32-W){1'b0}}, rdata_r} :
        sel_ctrl ? {29'h000_0000, depth_r, 2'b00} : 32'h0000_0000;

    // Sequencer: each strobe is held low, then all strobes rest high.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        pins_nxt = pins_r;
        case (state_r)
            AFC_IDLE: begin
                if (go_mr) begin
                    state_nxt = AFC_MR_LOW;
                    pins_nxt.master_clear_n = 1'b0;
                    cnt_nxt = AFC_CW'(AFC_STROBE_CYC - 1);
                end else if (go_rt) begin
                    state_nxt = AFC_RT_LOW;
                    pins_nxt.rewind_n = 1'b0;
                    cnt_nxt = AFC_CW'(AFC_STROBE_CYC - 1);
                end else if (go_rd) begin
                    state_nxt = AFC_RD_LOW;
                    pins_nxt.read_n = 1'b0;
                    cnt_nxt = AFC_CW'(AFC_STROBE_CYC - 1);
                end else if (go_wr) begin
                    state_nxt = AFC_WR_LOW;
                    pins_nxt.write_n = 1'b0;
                    cnt_nxt = AFC_CW'(AFC_STROBE_CYC - 1);
                end
            end
            AFC_RD_LOW, AFC_MR_LOW: begin
                if (cnt_done) begin
                    state_nxt = AFC_RECOV;
                    pins_nxt.read_n = 1'b1;
                    pins_nxt.master_clear_n = 1'b1;
                    cnt_nxt = AFC_CW'(AFC_RECOVER_CYC - 1);
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            AFC_WR_LOW: begin
                if (cnt_done) begin
                    // Wait the empty release delay before any next read.
                    state_nxt = AFC_RECOV;
                    pins_nxt.write_n = 1'b1;
                    cnt_nxt = AFC_CW'(AFC_EREL_CYC - 1);
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            AFC_RT_LOW: begin
                if (cnt_done) begin
                    // Strobes stay high through rewind recovery.
                    state_nxt = AFC_RECOV;
                    pins_nxt.rewind_n = 1'b1;
                    cnt_nxt = AFC_CW'(AFC_RTR_CYC - 1);
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            AFC_RECOV: begin
                if (cnt_done) begin
                    state_nxt = AFC_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = AFC_IDLE;
                pins_nxt = '1;
            end
        endcase
    end

    // State, strobe and counter registers.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state_r <= AFC_IDLE;
            cnt_r <= '0;
            pins_r <= '1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pins_r <= pins_nxt;
        end
    end

    // Data capture: sample outputs at the end of the low read phase,
    // since the device floats them once the strobe rises.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_r <= '0;
            wdata_r <= '0;
        end else begin
            if (state_r == AFC_RD_LOW && cnt_done) begin
                rdata_r <= DATA_OUT_BUS;
            end
            if (go_wr) begin
                wdata_r <= AVS_WRITEDATA[W-1:0];
            end
        end
    end

    // Strap and refusal flag; a new refusal wins over the clear.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            depth_r <= 1'b0;
            rd_refused_r <= 1'b0;
        end else begin
            if (go_mr) begin
                depth_r <= AVS_WRITEDATA[AFC_CTRL_DEPTH];
            end
            if (take & AVS_READ & sel_rd & sys_empty) begin
                rd_refused_r <= 1'b1;
            end else if (take & AVS_READ & sel_st) begin
                rd_refused_r <= 1'b0;
            end
        end
    end

    // Bus answer: waitrequest drops for one cycle when an access is taken.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            wait_r <= 1'b1;
            rdout_r <= '0;
        end else begin
            wait_r <= ~take;
            if (take) begin
                rdout_r <= rd_word;
            end
        end
    end

    // Straps: standalone ties chain-in low and first-load high.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            CHAIN_IN_N <= 1'b0;
            FIRST_LOAD_N <= 1'b1;
        end else begin
            CHAIN_IN_N <= 1'b0;
            FIRST_LOAD_N <= ~depth_r;
        end
    end

    // Ports come straight from flip-flops.
    assign READ_N = pins_r.read_n;
    assign WRITE_N = pins_r.write_n;
    assign REWIND_N = pins_r.rewind_n;
    assign MASTER_CLEAR_N = pins_r.master_clear_n;
    assign DATA_IN_BUS = wdata_r;
    assign AVS_READDATA = rdout_r;
    assign AVS_WAITREQUEST = wait_r;
endmodule : afc_host

// ===== rtl/afc_pkg.sv
// Package for the asynchronous FIFO host controller: map, timing, types.
package afc_pkg;
    // Data width of one FIFO device slice.
    localparam int AFC_DW = 9;
    // Controller register byte addresses (word aligned).
    localparam logic [3:0] AFC_REG_CTRL = 4'h0;
    localparam logic [3:0] AFC_REG_WDATA = 4'h4;
    localparam logic [3:0] AFC_REG_RDATA = 4'h8;
    localparam logic [3:0] AFC_REG_STAT = 4'hC;
    // Control register bit positions.
    localparam int AFC_CTRL_RESET = 0;
    localparam int AFC_CTRL_REWIND = 1;
    localparam int AFC_CTRL_DEPTH = 2;
    // Timing figures in nanoseconds and the clock period.
    localparam int AFC_CLK_NS = 50;
    localparam int AFC_STROBE_NS = 65;
    localparam int AFC_RECOVER_NS = 15;
    localparam int AFC_EMPTY_RELEASE_NS = 60;
    localparam int AFC_REWIND_RECOVERY_NS = 15;
    // Least times rounded up to whole cycles, at least one cycle.
    localparam int AFC_STROBE_CYC = (AFC_STROBE_NS + AFC_CLK_NS - 1) / AFC_CLK_NS;
    localparam int AFC_RECOVER_CYC = (AFC_RECOVER_NS + AFC_CLK_NS - 1) / AFC_CLK_NS;
    localparam int AFC_EREL_CYC =
        (AFC_EMPTY_RELEASE_NS + AFC_CLK_NS - 1) / AFC_CLK_NS;
    localparam int AFC_RTR_CYC =
        (AFC_REWIND_RECOVERY_NS + AFC_CLK_NS - 1) / AFC_CLK_NS;
    // Width of the timing counter.
    localparam int AFC_CW = 4;
    // Controller sequencer states.
    typedef enum logic [2:0] {
        AFC_IDLE = 3'b000,
        AFC_RD_LOW = 3'b001,
        AFC_WR_LOW = 3'b010,
        AFC_RT_LOW = 3'b011,
        AFC_MR_LOW = 3'b100,
        AFC_RECOV = 3'b101
    } afc_state_type;
    // Strobe pins toward the FIFO device, all active low.
    typedef struct packed {
        logic read_n;
        logic write_n;
        logic rewind_n;
        logic master_clear_n;
    } afc_strobe_type;
endpackage : afc_pkg

// ===== testbench/afc_fifo_model.sv
// Behavioural model of the asynchronous 9-bit FIFO device.
`timescale 1ns/1ps
module afc_fifo_model #(parameter int DEPTH = 4) (
    input wire logic read_n, write_n, rewind_n, master_clear_n,
    input wire logic [8:0] data_in_bus,
    output logic [8:0] data_out_bus,
    output logic empty_flag_n, full_flag_n, half_level_flag_n
);
    logic [8:0] mem [DEPTH];
    logic [8:0] last = '0;
    logic drv = 1'b0;
    int rp = 0, wp = 0, cnt = 0, nw = 0;
    // Flags follow the pointer distance at once on any strobe edge.
    assign empty_flag_n = (cnt != 0);
    assign full_flag_n = (cnt != DEPTH);
    assign half_level_flag_n = !(cnt > DEPTH / 2);
    // Released outputs show the inverse of the last word, not a copy.
    assign data_out_bus = drv ? last : ~last;
    // A read on an empty device is dropped and the pointer holds.
    always @(negedge read_n) begin
        if (cnt != 0) begin
            last = mem[rp];
            drv = 1'b1;
            rp = (rp + 1) % DEPTH;
            cnt--;
        end
    end
    always @(posedge read_n) drv = 1'b0;
    // A write stores on the rising strobe unless the device is full.
    always @(posedge write_n) begin
        if (cnt != DEPTH) begin
            mem[wp] = data_in_bus;
            wp = (wp + 1) % DEPTH;
            cnt++;
            nw++;
        end
    end
    // Rewind homes the read pointer and recomputes the fill level.
    always @(negedge rewind_n) begin
        rp = 0;
        cnt = (nw > DEPTH) ? DEPTH : nw;
    end
    // Master clear empties the device.
    always @(negedge master_clear_n) begin
        rp = 0;
        wp = 0;
        cnt = 0;
        nw = 0;
    end
endmodule : afc_fifo_model

// ===== testbench/afc_host_chk.sv
// Checker of the host controller strobes toward the FIFO device.
`timescale 1ns/1ps
module afc_host_chk import afc_pkg::*;
#(parameter int SLICES = 1, parameter int DEVS = 1) (
    input wire logic CLK, RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic [31:0] AVS_WRITEDATA, AVS_READDATA,
    input wire logic READ_N, WRITE_N, REWIND_N, MASTER_CLEAR_N,
    input wire logic [SLICES*AFC_DW-1:0] DATA_IN_BUS, DATA_OUT_BUS,
    input wire logic [DEVS-1:0] EMPTY_FLAG_N, FULL_FLAG_N,
    input wire logic HALF_LEVEL_FLAG_N, CHAIN_IN_N, FIRST_LOAD_N
);
    // All checks run on the controller clock and pause in reset.
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_rd_gate; $fell(READ_N) |-> &$past(EMPTY_FLAG_N); endproperty
    a_rd_gate: assert property (p_rd_gate) else $error("read on empty");
    property p_wr_gate; $fell(WRITE_N) |-> &$past(FULL_FLAG_N); endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("write on full");
    property p_rd_len; $fell(READ_N) |-> !READ_N[*2] ##1 READ_N; endproperty
    a_rd_len: assert property (p_rd_len) else $error("read pulse");
    property p_wr_len;
        $fell(WRITE_N) |-> !WRITE_N[*2] ##1 WRITE_N[*2];
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write pulse");
    property p_rt_quiet; !REWIND_N |-> READ_N && WRITE_N; endproperty
    a_rt_quiet: assert property (p_rt_quiet) else $error("rewind busy");
    property p_rt_len;
        $fell(REWIND_N) |-> !REWIND_N[*2] ##1 (REWIND_N && READ_N && WRITE_N);
    endproperty
    a_rt_len: assert property (p_rt_len) else $error("rewind pulse");
    property p_rt_depth; !FIRST_LOAD_N |-> REWIND_N; endproperty
    a_rt_depth: assert property (p_rt_depth) else $error("depth rewind");
    property p_mr_quiet; !MASTER_CLEAR_N |-> READ_N && WRITE_N; endproperty
    a_mr_quiet: assert property (p_mr_quiet) else $error("clear busy");
endmodule : afc_host_chk
bind afc_host afc_host_chk #(.SLICES(SLICES), .DEVS(DEVS)) afc_host_chk_i (
    .CLK, .RST, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .AVS_ADDRESS,
    .AVS_WRITEDATA, .AVS_READDATA, .READ_N, .WRITE_N, .REWIND_N,
    .MASTER_CLEAR_N, .DATA_IN_BUS, .DATA_OUT_BUS, .EMPTY_FLAG_N,
    .FULL_FLAG_N, .HALF_LEVEL_FLAG_N, .CHAIN_IN_N, .FIRST_LOAD_N);

// ===== testbench/testbench.sv
// Testbench of the FIFO host controller against the device model.
`timescale 1ns/1ps
module testbench import afc_pkg::*;
;
    logic CLK = 1'b0, RST = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
    logic [3:0] AVS_ADDRESS = '0;
    logic [31:0] AVS_WRITEDATA = '0, AVS_READDATA, rd;
    logic AVS_WAITREQUEST, READ_N, WRITE_N, REWIND_N, MASTER_CLEAR_N;
    logic HALF_LEVEL_FLAG_N, CHAIN_IN_N, FIRST_LOAD_N;
    logic [0:0] EMPTY_FLAG_N, FULL_FLAG_N;
    logic [8:0] DATA_IN_BUS, DATA_OUT_BUS, wd [4];
    int mismatches = 0, tests_run = 0;
    afc_host #(.SLICES(1), .DEVS(1)) afc_host_i (.CLK, .RST, .AVS_ADDRESS,
        .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_READDATA,
        .AVS_WAITREQUEST, .READ_N, .WRITE_N, .REWIND_N, .MASTER_CLEAR_N,
        .DATA_IN_BUS, .DATA_OUT_BUS, .EMPTY_FLAG_N, .FULL_FLAG_N,
        .HALF_LEVEL_FLAG_N, .CHAIN_IN_N, .FIRST_LOAD_N);
    afc_fifo_model #(.DEPTH(4)) afc_fifo_model_i (.read_n(READ_N),
        .write_n(WRITE_N), .rewind_n(REWIND_N),
        .master_clear_n(MASTER_CLEAR_N), .data_in_bus(DATA_IN_BUS),
        .data_out_bus(DATA_OUT_BUS), .empty_flag_n(EMPTY_FLAG_N[0]),
        .full_flag_n(FULL_FLAG_N[0]), .half_level_flag_n(HALF_LEVEL_FLAG_N));
    initial forever #25 CLK = ~CLK;
    task automatic give_verdict;
        $display("Compared %0d, mismatched %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // One bus access, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input int d);
        int n;
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        n = 0;
        do begin
            @(posedge CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 100);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        if (AVS_WAITREQUEST !== 1'b0) begin
            mismatches++;
            give_verdict();
        end
    endtask : bus
    task automatic stat(input logic [5:0] e);
        bus(1'b0, AFC_REG_STAT, 0);
        check("stat", rd, {26'h0, e});
    endtask : stat
    task automatic fill(input int lo, hi);
        for (int k = lo; k < hi; k++) bus(1'b1, AFC_REG_WDATA, wd[k]);
    endtask : fill
    // Each read returns the word fetched by the read before it.
    task automatic drain(input int n);
        for (int k = 0; k <= n; k++) begin
            bus(1'b0, AFC_REG_RDATA, 0);
            if (k > 0) check("rdata", rd, {23'h0, wd[k-1]});
        end
    endtask : drain
    initial begin
        foreach (wd[k]) wd[k] = 9'h1A0 + 9'(k);
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        bus(1'b1, AFC_REG_CTRL, 32'h0000_0001);
        check("chain", {31'h0, CHAIN_IN_N}, 0);
        stat(6'h02);
        bus(1'b0, AFC_REG_RDATA, 0);
        check("rdata", rd, 0);
        stat(6'h22);
        fill(0, 4);
        bus(1'b1, AFC_REG_WDATA, 32'h0000_00FF);
        stat(6'h0C);
        drain(4);
        stat(6'h22);
        bus(1'b1, AFC_REG_CTRL, 32'h0000_0002);
        stat(6'h0C);
        drain(4);
        bus(1'b1, AFC_REG_CTRL, 32'h0000_0001);
        fill(0, 2);
        drain(2);
        bus(1'b1, AFC_REG_CTRL, 32'h0000_0002);
        fill(2, 3);
        drain(3);
        stat(6'h22);
        bus(1'b1, AFC_REG_CTRL, 32'h0000_0005);
        bus(1'b1, AFC_REG_CTRL, 32'h0000_0002);
        stat(6'h12);
        check("first", {31'h0, FIRST_LOAD_N}, 0);
        give_verdict();
    end
endmodule : testbench
